// File: core/srp_pkg.sv
// constants for the special function register page decoder
package srp_pkg;
  localparam logic [7:0] SFR_BASE         = 8'h80;
  localparam logic [7:0] PAGE_SEL_ADDR    = 8'ha7;
  localparam logic [7:0] PAGE_SEL_RESET   = 8'h00;
  localparam logic [7:0] PAGE_DEFAULT     = 8'h00;
  localparam logic [7:0] PAGE_EXTENDED    = 8'h0f;
  localparam logic [3:0] BIT_ADDR_NIB_LO  = 4'h0;
  localparam logic [3:0] BIT_ADDR_NIB_HI  = 4'h8;
  // shared core registers
  localparam logic [7:0] ADDR_PORT0       = 8'h80;
  localparam logic [7:0] ADDR_STACK_PTR   = 8'h81;
  localparam logic [7:0] ADDR_DPTR_LOW    = 8'h82;
  localparam logic [7:0] ADDR_DPTR_HIGH   = 8'h83;
  localparam logic [7:0] ADDR_POWER_CTL   = 8'h87;
  localparam logic [7:0] ADDR_PORT1       = 8'h90;
  localparam logic [7:0] ADDR_PORT2       = 8'ha0;
  localparam logic [7:0] ADDR_IRQ_EN      = 8'ha8;
  localparam logic [7:0] ADDR_CLK_SEL     = 8'ha9;
  localparam logic [7:0] ADDR_PSW         = 8'hd0;
  localparam logic [7:0] ADDR_ACC         = 8'he0;
  localparam logic [7:0] ADDR_EXT_IRQ_EN1 = 8'he6;
  localparam logic [7:0] ADDR_EXT_IRQ_EN2 = 8'he7;
  localparam logic [7:0] ADDR_B_REG       = 8'hf0;
  localparam logic [7:0] ADDR_EXT_PRIO1   = 8'hf6;
  localparam logic [7:0] ADDR_EXT_PRIO2   = 8'hf7;
  // page 0xf registers, then page 0 names sharing their addresses
  localparam logic [7:0] ADDR_TEMP_OFF_LO = 8'h85;
  localparam logic [7:0] ADDR_TEMP_OFF_HI = 8'h86;
  localparam logic [7:0] ADDR_CHECKSUM_LO = 8'h91;
  localparam logic [7:0] ADDR_CHECKSUM_HI = 8'h97;
  localparam logic [7:0] ADDR_DRIVE_LO    = 8'ha4;
  localparam logic [7:0] ADDR_DRIVE_HI    = 8'ha6;
  localparam logic [7:0] ADDR_CONV_BURST  = 8'hba;
  localparam logic [7:0] ADDR_CONV_TRACK  = 8'hbd;
  localparam logic [7:0] ADDR_OUT_MODE0   = 8'ha4;
  localparam logic [7:0] ADDR_CONV_ACCUM  = 8'hba;
  typedef enum logic [1:0] {
    SRP_BANK_NONE   = 2'b00,
    SRP_BANK_SHARED = 2'b01,
    SRP_BANK_PAGE0  = 2'b10,
    SRP_BANK_PAGEF  = 2'b11
  } srp_bank_t;
endpackage

// File: core/srp_map.sv
// combinational page/address classifier
`timescale 1ns/1ps
module srp_map (
  // access
  input  wire logic [7:0]         i_addr,
  input  wire logic [7:0]         i_page,
  // result
  output srp_pkg::srp_bank_t      o_bank,
  output logic                    o_bit_ok
);
  function automatic logic is_shared(input logic [7:0] a);
    is_shared = (a == srp_pkg::ADDR_PORT0) || (a == srp_pkg::ADDR_STACK_PTR) ||
                (a == srp_pkg::ADDR_DPTR_LOW) || (a == srp_pkg::ADDR_DPTR_HIGH) ||
                (a == srp_pkg::ADDR_POWER_CTL) || (a == srp_pkg::ADDR_PORT1) ||
                (a == srp_pkg::ADDR_PORT2) || (a == srp_pkg::ADDR_IRQ_EN) ||
                (a == srp_pkg::ADDR_CLK_SEL) || (a == srp_pkg::ADDR_PSW) ||
                (a == srp_pkg::ADDR_ACC) || (a == srp_pkg::ADDR_EXT_IRQ_EN1) ||
                (a == srp_pkg::ADDR_EXT_IRQ_EN2) || (a == srp_pkg::ADDR_B_REG) ||
                (a == srp_pkg::ADDR_EXT_PRIO1) || (a == srp_pkg::ADDR_EXT_PRIO2) ||
                (a == srp_pkg::PAGE_SEL_ADDR);
  endfunction
  function automatic logic is_page_f(input logic [7:0] a);
    is_page_f = (a == srp_pkg::ADDR_TEMP_OFF_LO) || (a == srp_pkg::ADDR_TEMP_OFF_HI) ||
                ((a >= srp_pkg::ADDR_CHECKSUM_LO) && (a <= srp_pkg::ADDR_CHECKSUM_HI)) ||
                ((a >= srp_pkg::ADDR_DRIVE_LO) && (a <= srp_pkg::ADDR_DRIVE_HI)) ||
                (a == srp_pkg::ADDR_CONV_BURST) || (a == srp_pkg::ADDR_CONV_TRACK);
  endfunction
  always_comb begin
    o_bit_ok = (i_addr[3:0] == srp_pkg::BIT_ADDR_NIB_LO) ||
               (i_addr[3:0] == srp_pkg::BIT_ADDR_NIB_HI);
    if (i_addr < srp_pkg::SFR_BASE) begin
      o_bank = srp_pkg::SRP_BANK_NONE;
    end else if (is_shared(i_addr)) begin
      o_bank = srp_pkg::SRP_BANK_SHARED;
    end else if (i_page == srp_pkg::PAGE_DEFAULT) begin
      o_bank = srp_pkg::SRP_BANK_PAGE0;
    end else if (i_page == srp_pkg::PAGE_EXTENDED) begin
      o_bank = is_page_f(i_addr) ? srp_pkg::SRP_BANK_PAGEF
                                 : srp_pkg::SRP_BANK_NONE;
    end else begin
      o_bank = srp_pkg::SRP_BANK_NONE;
    end
  end
endmodule // srp_map

// File: core/srp_decoder.sv
// page-select register and access steering for the register space
// Behaviour
// - decode 0x80-0xFF together with page select
// - unwritten page select routes to page 0
// - 8-bit page select at 0xA7, all pages
// - page select steers reads, writes, modify-writes
// - core registers answer on both pages
// - shared addresses reach the same register whatever the current page
// - page F holds checksum, drive, offset, tracking
// - 0xA4 output mode page 0, drive page F
// - addresses ending 0 or 8 bit-addressable
`timescale 1ns/1ps
module srp_decoder (
  // clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RESET_N,
  // core access, same clock
  input  wire logic       I_VALID,
  input  wire logic       I_WRITE,
  input  wire logic       I_BIT_ACCESS,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  // peripheral read data of the addressed register
  input  wire logic [7:0] I_PERIPH_RDATA,
  // registered answer
  output logic [7:0]      O_RDATA,
  output logic            O_RVALID,
  // registered peripheral strobes
  output logic            O_PERIPH_SEL,
  output logic            O_PERIPH_WE,
  output logic [1:0]      O_PERIPH_BANK,
  output logic [7:0]      O_PERIPH_ADDR,
  output logic [7:0]      O_PERIPH_WDATA,
  output logic [7:0]      O_PAGE
);
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] rdata;
    logic       rvalid;
    logic       sel;
    logic       we;
    logic [1:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } srp_state_t;

  srp_state_t          st_r;
  srp_state_t          st_nxt;
  logic [1:0]          rst_sync_r;
  srp_pkg::srp_bank_t  bank;
  logic                bit_ok;
  logic                rst_n;
  logic                hit_page;
  logic                legal;

  // release reset through two stages; kept out of the state struct because the pin
  // clears it while its own output clears everything else
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // page used is the live register, so a page write steers the next access
  srp_map u_map (
    .i_addr   (I_ADDR),
    .i_page   (st_r.page),
    .o_bank   (bank),
    .o_bit_ok (bit_ok)
  );

  assign hit_page = (I_ADDR == srp_pkg::PAGE_SEL_ADDR);
  // bit access to a byte-only register is refused
  assign legal    = I_VALID && (bank != srp_pkg::SRP_BANK_NONE) &&
                    (!I_BIT_ACCESS || bit_ok);

  always_comb begin
    st_nxt          = st_r;
    st_nxt.rvalid   = I_VALID && !I_WRITE;
    st_nxt.rdata    = 8'h00;
    st_nxt.sel      = 1'b0;
    st_nxt.we       = 1'b0;
    if (legal) begin
      if (hit_page) begin
        if (I_WRITE) begin
          st_nxt.page = I_WDATA;
        end else begin
          st_nxt.rdata = st_r.page;
        end
      end else begin
        // peripherals answer combinationally within the access cycle
        st_nxt.sel   = 1'b1;
        st_nxt.we    = I_WRITE;
        st_nxt.bank  = bank;
        st_nxt.addr  = I_ADDR;
        st_nxt.wdata = I_WDATA;
        if (!I_WRITE) begin
          st_nxt.rdata = I_PERIPH_RDATA;
        end
      end
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r.page   <= srp_pkg::PAGE_SEL_RESET;
      st_r.rdata  <= 8'h00;
      st_r.rvalid <= 1'b0;
      st_r.sel    <= 1'b0;
      st_r.we     <= 1'b0;
      st_r.bank   <= 2'h0;
      st_r.addr   <= 8'h00;
      st_r.wdata  <= 8'h00;
    end else begin
      st_r.page   <= st_nxt.page;
      st_r.rdata  <= st_nxt.rdata;
      st_r.rvalid <= st_nxt.rvalid;
      st_r.sel    <= st_nxt.sel;
      st_r.we     <= st_nxt.we;
      st_r.bank   <= st_nxt.bank;
      st_r.addr   <= st_nxt.addr;
      st_r.wdata  <= st_nxt.wdata;
    end
  end

  assign O_RDATA        = st_r.rdata;
  assign O_RVALID       = st_r.rvalid;
  assign O_PERIPH_SEL   = st_r.sel;
  assign O_PERIPH_WE    = st_r.we;
  assign O_PERIPH_BANK  = st_r.bank;
  assign O_PERIPH_ADDR  = st_r.addr;
  assign O_PERIPH_WDATA = st_r.wdata;
  assign O_PAGE         = st_r.page;
endmodule // srp_decoder

// File: sim/srp_decoder_checker.sv
// port assertions for the register page decoder
`timescale 1ns/1ps
module srp_decoder_checker (
  // clock, reset and request
  input wire logic       I_CLK,
  input wire logic       I_RESET_N,
  input wire logic       I_VALID,
  input wire logic       I_WRITE,
  input wire logic       I_BIT_ACCESS,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  // answer
  input wire logic [7:0] O_RDATA,
  input wire logic       O_RVALID,
  input wire logic       O_PERIPH_SEL,
  input wire logic [1:0] O_PERIPH_BANK,
  input wire logic [7:0] O_PAGE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire pg_wr = I_VALID && I_WRITE && I_ADDR == 8'ha7;
  a_read_answer: assert property (I_VALID && !I_WRITE |=> O_RVALID)
    else $error("read not answered");
  a_low_refused: assert property (
    I_VALID && !I_ADDR[7] |=> !O_PERIPH_SEL && O_RDATA == 8'h00)
    else $error("low address forwarded");
  a_page_write: assert property (
    pg_wr && !I_BIT_ACCESS |=> O_PAGE == $past(I_WDATA))
    else $error("page write lost");
  a_page_hold: assert property (!pg_wr |=> $stable(O_PAGE))
    else $error("page changed");
  a_bit_refused: assert property (
    I_VALID && I_BIT_ACCESS && I_ADDR[2:0] != 3'h0 |=> !O_PERIPH_SEL)
    else $error("bit access forwarded");
  a_shared_any: assert property (
    I_VALID && I_ADDR == 8'he0 |=> O_PERIPH_SEL && O_PERIPH_BANK == 2'h1)
    else $error("shared register missed");
  a_pagef_steer: assert property (
    I_VALID && !I_BIT_ACCESS && O_PAGE == 8'h0f && I_ADDR == 8'hba
    |=> O_PERIPH_SEL && O_PERIPH_BANK == 2'h3)
    else $error("page f steering");
  a_odd_page: assert property (
    I_VALID && O_PAGE != 8'h00 && O_PAGE != 8'h0f && I_ADDR == 8'hba |=> !O_PERIPH_SEL)
    else $error("odd page forwarded");
endmodule // srp_decoder_checker
bind srp_decoder srp_decoder_checker i_chk (
  .I_CLK         (I_CLK),
  .I_RESET_N     (I_RESET_N),
  .I_VALID       (I_VALID),
  .I_WRITE       (I_WRITE),
  .I_BIT_ACCESS  (I_BIT_ACCESS),
  .I_ADDR        (I_ADDR),
  .I_WDATA       (I_WDATA),
  .O_RDATA       (O_RDATA),
  .O_RVALID      (O_RVALID),
  .O_PERIPH_SEL  (O_PERIPH_SEL),
  .O_PERIPH_BANK (O_PERIPH_BANK),
  .O_PAGE        (O_PAGE)
);

// File: sim/srp_decoder_tb.sv
// self-checking bench for the register page decoder
`timescale 1ns/1ps
`define CHK(n,e,g) begin n_compared++; if ((g) !== (e)) begin \
  $display("ERROR %s exp %h got %h", n, e, g); miscompares++; end end
module srp_decoder_tb;
  logic       clk = 0, rst_n = 0, vld = 0, wr = 0, bit_acc = 0, rvalid, psel, pwe, p_v = 0, p_w;
  logic [7:0] addr = 0, wdata = 0, prd = 0, page = 0, lf = 8'h5c, rdata, paddr, pwdata, opage;
  logic [7:0] p_a, p_d, p_wd, r;
  logic [1:0] pbank, p_b;
  int         miscompares = 0, n_compared = 0, cyc = 0;
  srp_decoder i_dut (
    .I_CLK          (clk),
    .I_RESET_N      (rst_n),
    .I_VALID        (vld),
    .I_WRITE        (wr),
    .I_BIT_ACCESS   (bit_acc),
    .I_ADDR         (addr),
    .I_WDATA        (wdata),
    .I_PERIPH_RDATA (prd),
    .O_RDATA        (rdata),
    .O_RVALID       (rvalid),
    .O_PERIPH_SEL   (psel),
    .O_PERIPH_WE    (pwe),
    .O_PERIPH_BANK  (pbank),
    .O_PERIPH_ADDR  (paddr),
    .O_PERIPH_WDATA (pwdata),
    .O_PAGE         (opage)
  );
  initial forever #25 clk = ~clk;
  function logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  // 0 refused, 1 shared, 2 page 0, 3 page f
  function automatic logic [1:0] bank_of(logic [7:0] a, p, logic b);
    if (!a[7] || (b && a[2:0] != 3'h0)) return 2'h0;
    if (a inside {8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'ha0, 8'ha7, 8'ha8, 8'ha9, 8'hd0,
                  8'he0, 8'he6, 8'he7, 8'hf0, 8'hf6, 8'hf7}) return 2'h1;
    if (p == 8'h00) return 2'h2;
    if (p == 8'h0f && a inside {8'h85, 8'h86, [8'h91:8'h97], [8'ha4:8'ha6], 8'hba, 8'hbd})
      return 2'h3;
    return 2'h0;
  endfunction
  // checks the answer to the previous request, then issues the next one back to back
  task automatic step(logic v, w, b, logic [7:0] a, d);
    logic fwd;
    @(negedge clk);
    // the page select is served locally, never forwarded
    fwd = p_v && p_b != 2'h0 && p_a != 8'ha7;
    `CHK("sel", fwd, psel)
    `CHK("we", fwd && p_w, pwe)
    if (fwd) `CHK("bank", p_b, pbank)
    if (fwd) `CHK("paddr", p_a, paddr)
    if (fwd && p_w) `CHK("pwdata", p_wd, pwdata)
    `CHK("rvalid", p_v && !p_w, rvalid)
    `CHK("rdata", (p_v && !p_w) ? p_d : 8'h00, rdata)
    `CHK("page", page, opage)
    p_v = v;
    p_w = w;
    p_a = a;
    p_wd = d;
    prd = rnd();
    p_b = bank_of(a, page, b);
    p_d = p_b == 2'h0 ? 8'h00 : (a == 8'ha7 ? page : prd);
    if (v && w && !b && a == 8'ha7) page = d;
    vld = v;
    wr = w;
    bit_acc = b;
    addr = a;
    wdata = d;
  endtask
  task final_report();
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 3000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    step(1, 0, 0, 8'ha7, 8'h00);
    // page f visit: select, access defined spots, then odd page 5, back to 0
    step(1, 1, 0, 8'ha7, 8'h0f);
    step(1, 0, 0, 8'hba, 8'h00);
    step(1, 0, 1, 8'h91, 8'h00);
    step(1, 1, 0, 8'ha7, 8'h05);
    step(1, 0, 0, 8'hba, 8'h00);
    step(1, 1, 0, 8'ha7, 8'h00);
    step(1, 0, 0, 8'ha4, 8'h00);
    // mostly real pages, sometimes an odd one so only shared registers remain
    for (int i = 0; i < 1500; i++) begin
      r = rnd();
      if (r[2:0] == 3'h0) step(1, 1, 0, 8'ha7, r[3] ? 8'h0f : (r[4] ? 8'h00 : rnd()));
      else step(r[7] | r[6], r[5], r[4] & r[3], rnd(), rnd());
    end
    // a reset in mid-run must drop a page f selection
    step(1, 1, 0, 8'ha7, 8'h0f);
    step(0, 0, 0, 8'h00, 8'h00);
    rst_n = 0;
    page = 8'h00;
    repeat (3) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    step(1, 0, 0, 8'ha7, 8'h00);
    step(1, 0, 0, 8'hba, 8'h00);
    step(0, 0, 0, 8'h00, 8'h00);
    final_report();
  end
endmodule // srp_decoder_tb
